// [design/pdc_pkg.sv]
`default_nettype none
package pdc_pkg;
  localparam int unsigned addr_w = 16;
  localparam int unsigned data_w = 8;
  localparam logic [15:0] port3_direction_addr = 16'hff23;
  localparam logic [15:0] port4_direction_addr = 16'hff24;
  localparam logic [15:0] port3_data_addr = 16'hff03;
  localparam logic [15:0] port4_data_addr = 16'hff04;
  localparam logic [7:0] dir_reset = 8'hff;
  localparam logic [7:0] latch_reset = 8'h00;
  localparam logic [7:0] port3_fixed_ones = 8'hfb;
  localparam int unsigned port3_pin2_dir_bit = 2;
  localparam int unsigned sync_stages = 3;
endpackage
`default_nettype wire

// [design/pdc_pin_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module pdc_pin_sync #(
  parameter int unsigned width = 8
) (
  // clocking
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // pins in, filtered level out
  input wire logic [width-1:0] pin_raw,
  output logic [width-1:0] pin_level
);
  logic [width-1:0] s1_q;
  logic [width-1:0] s2_q;
  logic [width-1:0] s3_q;
  logic [width-1:0] lvl_q;
  // elaboration-time refusal of an empty pin group
  generate
    if (width < 1)
    begin : g_bad_width
      $error("pdc_pin_sync: width must be at least 1");
    end
  endgenerate
  // three stages; level moves only when stages two and three agree
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end
    else if (clk_en)
    begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end
  end
  assign pin_level = lvl_q;
endmodule // pdc_pin_sync
`default_nettype wire

// [design/pdc_port_dir.sv]
`timescale 1ns/10ps
`default_nettype none
module pdc_port_dir #(
  // bus widths fixed by the cpu register map
  parameter int unsigned addr_w = 16,
  parameter int unsigned data_w = 8,
  // pins of port 4, one direction bit each
  parameter int unsigned port4_pins = 8
) (
  // clocking
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // cpu register port
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_bit_op,
  input wire logic [2:0] cpu_bit_sel,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_rd,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  // output latch values from the data registers
  input wire logic port3_pin2_latch,
  input wire logic [7:0] port4_latch,
  // port 3 pin 2
  input wire logic port3_pin2_i,
  output logic port3_pin2_o,
  output logic port3_pin2_oe,
  // port 4 pins
  input wire logic [7:0] port4_pin_i,
  output logic [7:0] port4_pin_o,
  output logic [7:0] port4_pin_oe,
  // direction bits for the rest of the port
  output logic [7:0] port3_direction,
  output logic [7:0] port4_direction
);
  logic dir3_q;
  logic [7:0] dir4_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic p3_o_q;
  logic p3_oe_q;
  logic [7:0] p4_o_q;
  logic [7:0] p4_oe_q;
  logic [8:0] pin_level;
  logic [7:0] wmask;
  logic [7:0] dir4_d;
  logic dir3_d;
  logic [7:0] p3_dir_view;
  logic [7:0] rdata_d;
  logic wr3_hit;
  logic wr4_hit;
  logic rd_hit;

  // register map as seen from the cpu side:
  //   port 3 direction, one live bit (pin 2), rest read one
  //   port 4 direction, eight live bits, one per pin
  //   port 3 and port 4 data, read only here
  // direction bit one means input, zero means output
  // reset leaves every direction bit at one, so no pin is driven
  // until software has chosen a direction on purpose
  // timing:
  //   write lands at the strobe edge
  //   pin enable follows one cycle later
  //   read answer and rvalid registered at the strobe edge
  // limitation: a write and a read in one cycle
  //   return the old direction value
  // clk_en low freezes everything, including the pin filter

  // the register map and the byte lanes below assume these sizes
  generate
    if (addr_w != 16)
    begin : g_bad_addr
      $error("pdc_port_dir: addr_w must be 16");
    end
    if (data_w != 8)
    begin : g_bad_data
      $error("pdc_port_dir: data_w must be 8");
    end
    if (port4_pins != 8)
    begin : g_bad_pins
      $error("pdc_port_dir: port4_pins must be 8");
    end
  endgenerate

  // decode once; clk_en gates every state change
  assign wr3_hit = clk_en && cpu_wr
    && cpu_addr == pdc_pkg::port3_direction_addr;
  assign wr4_hit = clk_en && cpu_wr
    && cpu_addr == pdc_pkg::port4_direction_addr;
  assign rd_hit = clk_en && cpu_rd;

  // external pins are foreign to this clock, so filter them
  pdc_pin_sync #(.width(9)) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .pin_raw({port3_pin2_i, port4_pin_i}),
    .pin_level(pin_level)
  );

  // bit op touches one lane, byte op all lanes
  always_comb
  begin
    wmask = cpu_bit_op ? (8'h01 << cpu_bit_sel) : 8'hff;
    dir3_d = wmask[pdc_pkg::port3_pin2_dir_bit]
      ? cpu_wdata[pdc_pkg::port3_pin2_dir_bit] : dir3_q;
  end

  // next value per lane: only masked lanes take new data
  generate
    for (genvar i = 0; i < 8; i++)
    begin : g_lane
      assign dir4_d[i] = wmask[i] ? cpu_wdata[i] : dir4_q[i];
    end
  endgenerate

  // port 3 direction: one storage bit only
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      dir3_q <= pdc_pkg::dir_reset[pdc_pkg::port3_pin2_dir_bit];
    else if (wr3_hit)
      dir3_q <= dir3_d;
  end

  // port 4 direction: eight independent bits
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      dir4_q <= pdc_pkg::dir_reset;
    else if (wr4_hit)
      dir4_q <= dir4_d;
  end

  // fixed bits forced high so they always read one
  assign p3_dir_view = pdc_pkg::port3_fixed_ones
    | ({7'h00, dir3_q} << pdc_pkg::port3_pin2_dir_bit);

  // read mux; data reads pick pin or latch by direction
  always_comb
  begin
    case (cpu_addr)
      pdc_pkg::port3_direction_addr: rdata_d = p3_dir_view;
      pdc_pkg::port4_direction_addr: rdata_d = dir4_q;
      pdc_pkg::port3_data_addr:
        rdata_d = {5'h00, (dir3_q ? pin_level[8] : port3_pin2_latch),
          2'b00};
      pdc_pkg::port4_data_addr:
        rdata_d = (dir4_q & pin_level[7:0])
          | (~dir4_q & port4_latch);
      default: rdata_d = 8'h00;
    endcase
  end

  // read strobe answered exactly one cycle later
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      rvalid_q <= 1'b0;
    else if (clk_en)
      rvalid_q <= rd_hit;
  end

  // rdata holds until the next read, so a slow master may sample late
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      rdata_q <= 8'h00;
    else if (rd_hit)
      rdata_q <= rdata_d;
  end

  // port 3 pin 2 driver; registered so the pad sees no decode glitch
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      p3_o_q <= 1'b0;
      p3_oe_q <= 1'b0;
    end
    else if (clk_en)
    begin
      p3_o_q <= port3_pin2_latch;
      p3_oe_q <= ~dir3_q;
    end
  end

  // port 4 drivers; oe low while the lane's bit is one
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      p4_o_q <= 8'h00;
      p4_oe_q <= 8'h00;
    end
    else if (clk_en)
    begin
      p4_o_q <= port4_latch;
      p4_oe_q <= ~dir4_q;
    end
  end

  // oe trails the register by one cycle; a limitation of registered outputs
  assign port3_pin2_o = p3_o_q;
  assign port3_pin2_oe = p3_oe_q;
  assign port4_pin_o = p4_o_q;
  assign port4_pin_oe = p4_oe_q;
  assign port3_direction = p3_dir_view;
  assign port4_direction = dir4_q;
  assign cpu_rdata = rdata_q;
  assign cpu_rvalid = rvalid_q;
endmodule // pdc_port_dir
`default_nettype wire

// [test/pdc_pin_model.sv]
`timescale 1ns/10ps
`default_nettype none
module pdc_pin_model (
  // device side and far-side level
  input wire logic [8:0] oe,
  input wire logic [8:0] o,
  input wire logic [8:0] ext,
  output logic [8:0] pin
);
  // undriven pin shows the far side, never a stale drive
  assign pin = (oe & o) | (~oe & ext);
endmodule // pdc_pin_model
`default_nettype wire

// [test/pdc_port_dir_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module pdc_port_dir_checker (
  // clock and cpu
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_bit_op,
  input wire logic [2:0] cpu_bit_sel,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_rdata,
  input wire logic cpu_rvalid,
  // direction and enables
  input wire logic port3_pin2_oe,
  input wire logic [7:0] port4_pin_oe,
  input wire logic [7:0] port3_direction,
  input wire logic [7:0] port4_direction
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // lanes touched by a write; byte write touches all
  logic w4;
  logic [7:0] m;
  assign w4 = clk_en && cpu_wr && cpu_addr == pdc_pkg::port4_direction_addr;
  assign m = cpu_bit_op ? 8'h01 << cpu_bit_sel : 8'hff;
  sequence rd_s;
    clk_en && cpu_rd;
  endsequence
  p3_fixed_a: assert property ((port3_direction | 8'h04) == 8'hff)
    else $error("p3 fixed");
  oe4_a: assert property (clk_en |=> port4_pin_oe == ~$past(port4_direction))
    else $error("oe4");
  oe3_a: assert property (clk_en |=> port3_pin2_oe == !$past(port3_direction[2]))
    else $error("oe3");
  wr4_a: assert property (w4 |=> port4_direction ==
    ($past(port4_direction) & ~$past(m) | $past(cpu_wdata) & $past(m)))
    else $error("wr4");
  hold4_a: assert property (!w4 |=> $stable(port4_direction))
    else $error("hold4");
  rd_valid_a: assert property (rd_s |=> cpu_rvalid)
    else $error("rvalid");
  rd_only_a: assert property (cpu_rvalid |-> $past(clk_en && cpu_rd))
    else $error("rvalid extra");
  rd_dir_a: assert property (rd_s ##0 cpu_addr == pdc_pkg::port4_direction_addr
    |=> cpu_rdata == $past(port4_direction)) else $error("rd dir");
endmodule // pdc_port_dir_checker
bind pdc_port_dir pdc_port_dir_checker chk_i (.*);
`default_nettype wire

// [test/pdc_port_dir_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module pdc_port_dir_tb;
  logic clock, cpu_rvalid, port3_pin2_i, port3_pin2_o, port3_pin2_oe;
  logic rst_b = 1'b0, clk_en = 1'b1, cpu_wr = 1'b0, cpu_rd = 1'b0;
  logic cpu_bit_op = 1'b0, port3_pin2_latch = 1'b1;
  logic [15:0] cpu_addr = 16'h0000;
  logic [2:0] cpu_bit_sel = 3'h0;
  logic [7:0] cpu_wdata = 8'h00, port4_latch = 8'ha5, ext = 8'h3c, e;
  logic [7:0] cpu_rdata, port4_pin_i, port4_pin_o, port4_pin_oe;
  logic [7:0] port3_direction, port4_direction;
  int n_mismatch, comparisons;
  localparam logic [15:0] d3 = pdc_pkg::port3_direction_addr;
  localparam logic [15:0] d4 = pdc_pkg::port4_direction_addr;
  pdc_port_dir uut (.*);
  pdc_pin_model pins (.oe({port3_pin2_oe, port4_pin_oe}),
    .o({port3_pin2_o, port4_pin_o}), .ext({ext[2], ext}),
    .pin({port3_pin2_i, port4_pin_i}));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  // strobe is dropped then one idle edge, so calls never collide
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
    input logic b, input logic [2:0] s);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_bit_op <= b;
    cpu_bit_sel <= s;
    cpu_wr <= 1'b1;
    @(posedge clock);
    cpu_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] x);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clock);
    cpu_rd <= 1'b0;
    #1;
    chk({7'h00, cpu_rvalid}, 8'h01);
    chk(cpu_rdata, x);
    @(posedge clock);
  endtask
  task automatic print_verdict;
    $display("%0d mismatches, %0d compares", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // whole run is about ninety cycles, far inside the 2500-cycle limit
  initial
  begin
    #20000;
    n_mismatch++;
    print_verdict;
  end
  initial
  begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    chk(port3_direction, pdc_pkg::dir_reset);
    chk(port4_pin_oe, 8'h00);
    rd(d4, 8'hff);
    $display("reset test done");
    wr(d4, 8'h0f, 1'b0, 3'h0);
    rd(d4, 8'h0f);
    chk(port4_pin_oe, 8'hf0);
    chk(port4_pin_o & port4_pin_oe, 8'ha0);
    // inverse data: a byte write would flip the other lanes too
    e = 8'h0f;
    for (int i = 0; i < 8; i++)
    begin
      wr(d4, ~e, 1'b1, 3'(i));
      e[i] = ~e[i];
      rd(d4, e);
    end
    $display("write test done");
    wr(d3, 8'h00, 1'b0, 3'h0);
    rd(d3, 8'hfb);
    chk({7'h00, port3_pin2_oe}, 8'h01);
    chk({7'h00, port3_pin2_o}, 8'h01);
    chk(port4_direction, 8'hf0);
    // let the pin filter settle
    repeat (6) @(posedge clock);
    rd(pdc_pkg::port4_data_addr, 8'h35);
    rd(pdc_pkg::port3_data_addr, 8'h04);
    $display("port test done");
    // pin 2 back to input; latch now differs from the far side
    port3_pin2_latch <= 1'b0;
    wr(d3, 8'hff, 1'b1, 3'h2);
    repeat (6) @(posedge clock);
    chk({7'h00, port3_pin2_oe}, 8'h00);
    rd(pdc_pkg::port3_data_addr, {5'h00, ext[2], 2'b00});
    // frozen clock enable and a stray address must leave state alone
    clk_en <= 1'b0;
    wr(d4, 8'h00, 1'b0, 3'h0);
    clk_en <= 1'b1;
    wr(16'hff25, 8'h00, 1'b0, 3'h0);
    rd(d4, 8'hf0);
    // second reset in mid-run
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    chk(port4_direction, pdc_pkg::dir_reset);
    rd(d3, 8'hff);
    $display("freeze and reset test done");
    print_verdict;
  end
endmodule // pdc_port_dir_tb
`default_nettype wire
